// ### verilog/ahp_pkg.sv
package ahp_pkg;

  // ------------------------------------------------------------
  // widths and pin positions
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam int PIN_SOUT = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_FRAME = 10;
  localparam int PIN_LATE = 11;
  localparam int DEV_NSYNC = 12;
  // cnv_n, cs_n, rd_n idle high
  localparam logic [DEV_NSYNC-1:0] DEV_SYNC_RST = 12'hE00;
  localparam int HOST_NSYNC = DATA_W + 1;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_NS = 40;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = CONV_TIME_NS / SYS_CLK_NS;
  localparam int ACQ_TIME_NS = 400;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
  localparam int INT_QUARTER_CYCLES = SCLK_PERIOD_NS / (4 * SYS_CLK_NS);
  localparam int LATE_PULSE_CYCLES = 4;
  localparam int CNV_LOW_CYCLES = 4;
  localparam int RD_SETTLE_CYCLES = 8;

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CV_ACQ = 3'h1,
    CV_READY = 3'h2,
    CV_CONV = 3'h4
  } ahp_conv_t;

  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_CNV = 7'h02,
    H_GAP = 7'h04,
    H_BUSY = 7'h08,
    H_SETTLE = 7'h10,
    H_XFER = 7'h20,
    H_END = 7'h40
  } ahp_host_st_t;

endpackage : ahp_pkg

// ### verilog/ahp_if.sv
interface ahp_if
  import ahp_pkg::*;
();
  // host driven straps and strobes
  logic cnv_n;
  logic cs_n;
  logic rd_n;
  logic power_down;
  logic port_select;
  logic clock_source_select;
  logic serial_clock_invert;
  logic frame_marker_polarity;
  logic read_timing_or_chain_in;
  logic low_power;
  logic fast_mode;
  logic host_sclk_o;
  logic host_sclk_oe;
  // device driven
  logic busy;
  logic [DATA_W-1:0] dev_data_o;
  logic [DATA_W-1:0] dev_data_oe;
  // resolved shared pins; an undriven pin reads low, as if pulled down
  wire [DATA_W-1:0] data_pin;

  for (genvar i = 0; i < DATA_W; i++)
  begin : g_pin
    if (i == PIN_SCLK)
    begin : g_sclk
      assign data_pin[i] = dev_data_oe[i] ? dev_data_o[i] :
                           (host_sclk_oe ? host_sclk_o : 1'b0);
    end
    else
    begin : g_data
      assign data_pin[i] = dev_data_oe[i] ? dev_data_o[i] : 1'b0;
    end
  end

  modport dev (
    input cnv_n, cs_n, rd_n, power_down, port_select, clock_source_select,
    input serial_clock_invert, frame_marker_polarity, read_timing_or_chain_in,
    input low_power, fast_mode, data_pin,
    output busy, dev_data_o, dev_data_oe
  );

  modport host (
    output cnv_n, cs_n, rd_n, power_down, port_select, clock_source_select,
    output serial_clock_invert, frame_marker_polarity, read_timing_or_chain_in,
    output low_power, fast_mode, host_sclk_o, host_sclk_oe,
    input busy, data_pin
  );

endinterface : ahp_if

// ### verilog/ahp_dev.sv
// Overview of operation
// RULE1: invert high: shift on falling, valid rising
// RULE2: invert low: shift on rising, valid falling
// RULE3: serial clock driven internally, else host
// RULE4: parallel mode: clock/frame/flag pins carry bits
// RULE5: frame marker only with internal clock
// RULE6: polarity low: marker high during data
// RULE7: polarity high: marker low during data
// RULE8: unfinished external read at completion flags late
// RULE9: upper bits driven only in parallel mode
// RULE10: busy high from start until result latched
// RULE11: bus enabled only with select and read low
// RULE12: chip select gates external serial clock
// RULE13: reset returns idle, aborts conversion
// RULE14: power down finishes conversion, blocks new
// RULE15: convert start falling edge begins conversion
// RULE16: low power: held start converts at acquisition end
// RULE17: serial result shifts out MSB first
// RULE18: internal clock: data valid both edges
// RULE19: read timing picks during or after conversion
// RULE20: bus pins released when not read
module ahp_dev
  import ahp_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int ACQ_CYC = ACQ_CYCLES,
  parameter int QTR_CYC = INT_QUARTER_CYCLES
)
(
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // converter core
  input wire logic [DATA_W-1:0] sample_data,
  output logic [DATA_W-1:0] result_ff,
  output logic result_new_ff,
  // host pins
  ahp_if.dev pins
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [DEV_NSYNC-1:0] sync_in;
  logic [DEV_NSYNC-1:0] sync1_ff;
  logic [DEV_NSYNC-1:0] sync2_ff;
  logic cnv_n_s, cs_n_s, rd_n_s, pd_s, ser_s, ext_s, inv_s, pol_s, rdc_s;
  logic lp_s, fast_s, sclk_s;

  assign sync_in = {pins.cnv_n, pins.cs_n, pins.rd_n, pins.power_down,
                    pins.port_select, pins.clock_source_select,
                    pins.serial_clock_invert, pins.frame_marker_polarity,
                    pins.read_timing_or_chain_in, pins.low_power, pins.fast_mode,
                    pins.data_pin[PIN_SCLK]};
  assign {cnv_n_s, cs_n_s, rd_n_s, pd_s, ser_s, ext_s, inv_s, pol_s, rdc_s,
          lp_s, fast_s, sclk_s} = sync2_ff;

  for (genvar i = 0; i < DEV_NSYNC; i++)
  begin : g_sync
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        sync1_ff[i] <= DEV_SYNC_RST[i];
        sync2_ff[i] <= DEV_SYNC_RST[i];
      end
      else
      begin
        sync1_ff[i] <= sync_in[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  logic cnv_prev_ff;
  logic sclk_prev_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnv_prev_ff <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      cnv_prev_ff <= cnv_n_s;
      sclk_prev_ff <= sclk_s;
    end
  end

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  ahp_conv_t cv_st_ff;
  logic [15:0] cv_cnt_ff;
  logic busy_ff;
  logic acq_end, conv_end, conv_start, cnv_fall, lp_mode;

  assign cnv_fall = cnv_prev_ff & ~cnv_n_s; // [RULE15]
  assign lp_mode = lp_s & ~fast_s;
  assign acq_end = (cv_st_ff == CV_ACQ) && (cv_cnt_ff == 16'(ACQ_CYC - 1));
  assign conv_end = (cv_st_ff == CV_CONV) && (cv_cnt_ff == 16'(CONV_CYC - 1));
  assign conv_start = ~pd_s && (((cv_st_ff == CV_READY) && cnv_fall) || // [RULE14] [RULE15]
                                (acq_end && lp_mode && ~cnv_n_s)); // [RULE16]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cv_st_ff <= CV_ACQ; // [RULE13]
      cv_cnt_ff <= 16'h0000;
    end
    else
    begin
      unique case (cv_st_ff)
        CV_ACQ:
        begin
          if (acq_end)
          begin
            cv_cnt_ff <= 16'h0000;
            cv_st_ff <= conv_start ? CV_CONV : CV_READY;
          end
          else
          begin
            cv_cnt_ff <= cv_cnt_ff + 16'h0001;
          end
        end
        CV_READY:
        begin
          cv_cnt_ff <= 16'h0000;
          if (conv_start)
          begin
            cv_st_ff <= CV_CONV;
          end
        end
        CV_CONV:
        begin
          if (conv_end)
          begin
            cv_cnt_ff <= 16'h0000;
            cv_st_ff <= CV_ACQ;
          end
          else
          begin
            cv_cnt_ff <= cv_cnt_ff + 16'h0001;
          end
        end
        default:
        begin
          cv_st_ff <= CV_ACQ;
          cv_cnt_ff <= 16'h0000;
        end
      endcase
    end
  end

  // busy drops in the cycle the result is latched
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      result_ff <= {DATA_W{1'b0}};
      result_new_ff <= 1'b0;
    end
    else
    begin
      result_new_ff <= conv_end;
      if (conv_start)
      begin
        busy_ff <= 1'b1; // [RULE10]
      end
      else if (conv_end)
      begin
        busy_ff <= 1'b0; // [RULE10]
        result_ff <= sample_data;
      end
    end
  end

  assign pins.busy = busy_ff;

  // ------------------------------------------------------------
  // serial shifter, both clock sources
  // ------------------------------------------------------------
  logic rd_en, sclk_rise, sclk_fall, ext_shift, late_hit;
  logic mst_go, mst_on_ff, q_end, per_end, mst_last, avail_ff;
  logic [DATA_W-1:0] shreg_ff;
  logic [CNT_W-1:0] ext_cnt_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic [7:0] q_ff;
  logic [1:0] ph_ff;
  logic [3:0] late_cnt_ff;

  assign rd_en = ~cs_n_s & ~rd_n_s;
  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_s & sclk_prev_ff;
  assign ext_shift = ser_s & ext_s & ~cs_n_s & // [RULE12]
                     (inv_s ? sclk_fall : sclk_rise) & // [RULE1] [RULE2]
                     (ext_cnt_ff != CNT_W'(DATA_W));
  assign late_hit = conv_end & ser_s & ext_s & (ext_cnt_ff != {CNT_W{1'b0}}) &
                    (ext_cnt_ff != CNT_W'(DATA_W)); // [RULE8]
  assign mst_go = ser_s & ~ext_s & rd_en & avail_ff & ~mst_on_ff &
                  (rdc_s | ~busy_ff); // [RULE19]
  assign q_end = q_ff == 8'(QTR_CYC - 1);
  assign per_end = mst_on_ff & q_end & (ph_ff == PH_LAST);
  assign mst_last = per_end & (bit_cnt_ff == CNT_W'(DATA_W - 1));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      shreg_ff <= {DATA_W{1'b0}};
      ext_cnt_ff <= {CNT_W{1'b0}};
    end
    else if (conv_end && ext_s)
    begin
      shreg_ff <= sample_data; // [RULE8]
      ext_cnt_ff <= {CNT_W{1'b0}};
    end
    else if (mst_go)
    begin
      shreg_ff <= result_ff;
    end
    else if (ext_shift)
    begin
      shreg_ff <= {shreg_ff[DATA_W-2:0], rdc_s}; // [RULE17]
      ext_cnt_ff <= ext_cnt_ff + CNT_W'(1);
    end
    else if (per_end)
    begin
      shreg_ff <= {shreg_ff[DATA_W-2:0], 1'b0}; // [RULE17]
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      late_cnt_ff <= 4'h0;
    end
    else if (late_hit)
    begin
      late_cnt_ff <= 4'(LATE_PULSE_CYCLES); // [RULE8]
    end
    else if (late_cnt_ff != 4'h0)
    begin
      late_cnt_ff <= late_cnt_ff - 4'h1;
    end
  end

  // new result wins over the end of the previous transfer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      avail_ff <= 1'b0;
    end
    else if (conv_end)
    begin
      avail_ff <= 1'b1;
    end
    else if (mst_last)
    begin
      avail_ff <= 1'b0;
    end
  end

  // internal clock: data moves mid low phase of the uninverted clock (mid high phase when inverted), stable at both edges
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mst_on_ff <= 1'b0;
      q_ff <= 8'h00;
      ph_ff <= 2'h0;
      bit_cnt_ff <= {CNT_W{1'b0}};
    end
    else if (mst_go)
    begin
      mst_on_ff <= 1'b1;
      q_ff <= 8'h00;
      ph_ff <= 2'h0;
      bit_cnt_ff <= {CNT_W{1'b0}};
    end
    else if (mst_on_ff)
    begin
      if (mst_last || !rd_en || !ser_s || ext_s)
      begin
        mst_on_ff <= 1'b0;
      end
      if (q_end)
      begin
        q_ff <= 8'h00;
        ph_ff <= ph_ff + 2'h1; // [RULE18]
      end
      else
      begin
        q_ff <= q_ff + 8'h01;
      end
      if (per_end)
      begin
        bit_cnt_ff <= bit_cnt_ff + CNT_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // shared output pins
  // ------------------------------------------------------------
  logic [DATA_W-1:0] data_o_ff, nxt_data_o;
  logic [DATA_W-1:0] data_oe_ff, nxt_data_oe;

  always_comb
  begin
    nxt_data_o = {DATA_W{1'b0}};
    nxt_data_oe = {DATA_W{1'b0}}; // [RULE20]
    if (!ser_s)
    begin
      nxt_data_o = result_ff; // [RULE4]
      nxt_data_oe = {DATA_W{rd_en}}; // [RULE9] [RULE11]
    end
    else
    begin
      nxt_data_o[PIN_SOUT] = shreg_ff[DATA_W-1]; // [RULE17]
      nxt_data_o[PIN_SCLK] = (mst_on_ff & (ph_ff[0] ^ ph_ff[1])) ^ inv_s; // [RULE18]
      nxt_data_o[PIN_FRAME] = mst_on_ff ^ pol_s; // [RULE6] [RULE7]
      nxt_data_o[PIN_LATE] = late_cnt_ff != 4'h0; // [RULE8]
      nxt_data_oe[PIN_SOUT] = rd_en; // [RULE11]
      nxt_data_oe[PIN_SCLK] = rd_en & ~ext_s; // [RULE3]
      nxt_data_oe[PIN_FRAME] = rd_en & ~ext_s; // [RULE5]
      nxt_data_oe[PIN_LATE] = rd_en & ext_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      data_o_ff <= {DATA_W{1'b0}};
      data_oe_ff <= {DATA_W{1'b0}};
    end
    else
    begin
      data_o_ff <= nxt_data_o;
      data_oe_ff <= nxt_data_oe;
    end
  end

  assign pins.dev_data_o = data_o_ff;
  assign pins.dev_data_oe = data_oe_ff;

endmodule : ahp_dev

// ### verilog/ahp_host.sv
module ahp_host
  import ahp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYCLES,
  parameter int SETTLE_CYC = RD_SETTLE_CYCLES
)
(
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // configuration
  input wire logic cfg_serial,
  input wire logic cfg_ext_clk,
  input wire logic cfg_sclk_inv,
  input wire logic cfg_frame_inv,
  input wire logic cfg_read_timing,
  input wire logic cfg_low_power,
  input wire logic cfg_fast,
  input wire logic cfg_power_down,
  // request and answer
  input wire logic sample_req,
  output logic [DATA_W-1:0] sample_ff,
  output logic sample_valid_ff,
  output logic idle_ff,
  // device pins
  ahp_if.host pins
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [HOST_NSYNC-1:0] sync1_ff;
  logic [HOST_NSYNC-1:0] sync2_ff;
  logic [HOST_NSYNC-1:0] sync_in;
  logic busy_s, sclk_prev_ff, sclk_rise;
  logic [DATA_W-1:0] data_s;

  assign sync_in = {pins.busy, pins.data_pin};
  assign {busy_s, data_s} = sync2_ff;

  for (genvar i = 0; i < HOST_NSYNC; i++)
  begin : g_sync
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
      end
      else
      begin
        sync1_ff[i] <= sync_in[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  assign sclk_rise = (data_s[PIN_SCLK] ^ cfg_sclk_inv) & ~sclk_prev_ff;

  // ------------------------------------------------------------
  // straps
  // ------------------------------------------------------------
  logic ps_ff, ext_ff, inv_ff, pol_ff, rdc_ff, lp_ff, fast_ff, pd_ff, sclk_oe_ff;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {ps_ff, ext_ff, inv_ff, pol_ff, rdc_ff, lp_ff, fast_ff, pd_ff} <= 8'h00;
      sclk_oe_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      {ps_ff, ext_ff, inv_ff, pol_ff, rdc_ff, lp_ff, fast_ff, pd_ff} <=
        {cfg_serial, cfg_ext_clk, cfg_sclk_inv, cfg_frame_inv, cfg_read_timing,
         cfg_low_power, cfg_fast, cfg_power_down};
      sclk_oe_ff <= cfg_serial & cfg_ext_clk; // [RULE3]
      sclk_prev_ff <= data_s[PIN_SCLK] ^ cfg_sclk_inv;
    end
  end

  // ------------------------------------------------------------
  // request sequencer
  // ------------------------------------------------------------
  ahp_host_st_t st_ff;
  logic [7:0] cnt_ff;
  logic [CNT_W-1:0] bits_ff;
  logic lvl_ff, cnv_n_ff, rd_act_ff, sclk_o_ff, half_end, bit_take;

  assign half_end = cnt_ff == 8'(HALF_CYC - 1);
  assign bit_take = ext_ff ? (half_end & ~lvl_ff) : sclk_rise;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= H_IDLE;
      cnt_ff <= 8'h00;
      bits_ff <= {CNT_W{1'b0}};
      lvl_ff <= 1'b0;
      sample_ff <= {DATA_W{1'b0}};
      sample_valid_ff <= 1'b0;
    end
    else
    begin
      sample_valid_ff <= 1'b0;
      cnt_ff <= cnt_ff + 8'h01;
      unique case (st_ff)
        H_IDLE:
        begin
          lvl_ff <= 1'b0;
          if (sample_req && !cfg_power_down)
          begin
            st_ff <= H_CNV;
            cnt_ff <= 8'h00;
          end
        end
        H_CNV, H_GAP:
        begin
          // retry the start edge until busy is seen
          if (busy_s)
          begin
            st_ff <= H_BUSY;
          end
          else if (cnt_ff == 8'(CNV_LOW_CYCLES - 1))
          begin
            st_ff <= (st_ff == H_CNV) ? H_GAP : H_CNV;
            cnt_ff <= 8'h00;
          end
        end
        H_BUSY:
        begin
          cnt_ff <= 8'h00;
          if (!busy_s)
          begin
            st_ff <= H_SETTLE;
          end
        end
        H_SETTLE:
        begin
          bits_ff <= {CNT_W{1'b0}};
          if (ps_ff && !ext_ff)
          begin
            st_ff <= H_XFER;
          end
          else if (cnt_ff == 8'(SETTLE_CYC - 1))
          begin
            cnt_ff <= 8'h00;
            if (!ps_ff)
            begin
              sample_ff <= data_s;
              st_ff <= H_END;
            end
            else
            begin
              st_ff <= H_XFER;
            end
          end
        end
        H_XFER:
        begin
          if (half_end)
          begin
            cnt_ff <= 8'h00;
            lvl_ff <= ~lvl_ff; // [RULE12]
          end
          if (bit_take)
          begin
            sample_ff <= {sample_ff[DATA_W-2:0], data_s[PIN_SOUT]};
            bits_ff <= bits_ff + CNT_W'(1);
            if (bits_ff == CNT_W'(DATA_W - 1))
            begin
              st_ff <= H_END;
            end
          end
        end
        H_END:
        begin
          sample_valid_ff <= 1'b1;
          lvl_ff <= 1'b0;
          st_ff <= H_IDLE;
        end
        default:
        begin
          st_ff <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnv_n_ff <= 1'b1;
      rd_act_ff <= 1'b0;
      sclk_o_ff <= 1'b0;
      idle_ff <= 1'b1;
    end
    else
    begin
      cnv_n_ff <= st_ff != H_CNV; // [RULE15]
      rd_act_ff <= (st_ff == H_SETTLE) || (st_ff == H_XFER); // [RULE11]
      sclk_o_ff <= lvl_ff ^ inv_ff;
      idle_ff <= st_ff == H_IDLE;
    end
  end

  assign pins.cnv_n = cnv_n_ff;
  assign pins.cs_n = ~rd_act_ff;
  assign pins.rd_n = ~rd_act_ff;
  assign pins.power_down = pd_ff;
  assign pins.port_select = ps_ff;
  assign pins.clock_source_select = ext_ff;
  assign pins.serial_clock_invert = inv_ff;
  assign pins.frame_marker_polarity = pol_ff;
  assign pins.read_timing_or_chain_in = rdc_ff;
  assign pins.low_power = lp_ff;
  assign pins.fast_mode = fast_ff;
  assign pins.host_sclk_o = sclk_o_ff;
  assign pins.host_sclk_oe = sclk_oe_ff;

endmodule : ahp_host

// ### dv/ahp_monitor.sv
module ahp_monitor
  import ahp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host driven
  input wire logic cnv_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic power_down,
  input wire logic port_select,
  input wire logic clock_source_select,
  input wire logic frame_marker_polarity,
  // device driven
  input wire logic busy,
  input wire logic [DATA_W-1:0] dev_data_o,
  input wire logic [DATA_W-1:0] dev_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  wire int_ser = port_select && !clock_source_select;
  wire ext_ser = port_select && clock_source_select;

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_conv_run;
    busy [*5] ##1 !busy;
  endsequence

  sequence s_sclk_edge;
    int_ser && dev_data_oe[PIN_SCLK] && $past(dev_data_oe[PIN_SCLK])
      && $changed(dev_data_o[PIN_SCLK]);
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_BUSY_SPAN: assert property ($rose(busy) |-> s_conv_run)
    else $error("busy length wrong");
  AST_START_CAUSE: assert property ($rose(busy) |-> !$past(cnv_n, 2) || !$past(cnv_n, 3))
    else $error("busy rose without start");
  AST_PD_BLOCK: assert property (power_down [*8] |-> !$rose(busy))
    else $error("start while powered down");
  AST_BUS_IDLE: assert property ((cs_n || rd_n) [*5] |-> dev_data_oe == 16'h0000)
    else $error("bus driven without read");
  AST_UPPER_HIZ: assert property (port_select |-> dev_data_oe[15:12] == 4'h0)
    else $error("upper bits driven in serial");
  AST_PAR_DRIVE: assert property ((!port_select && !cs_n && !rd_n) [*5] |-> &dev_data_oe)
    else $error("parallel bus not driven");
  AST_SCLK_DIR: assert property (ext_ser |-> !dev_data_oe[PIN_SCLK])
    else $error("sclk driven in external mode");
  AST_FRAME_EXT: assert property (ext_ser |-> !dev_data_oe[PIN_FRAME])
    else $error("frame driven in external mode");
  AST_FRAME_POL: assert property (s_sclk_edge |-> dev_data_o[PIN_FRAME] != frame_marker_polarity)
    else $error("frame inactive while clocking");
  AST_SOUT_STEADY: assert property (s_sclk_edge |-> $stable(dev_data_o[PIN_SOUT]))
    else $error("data moved on sclk edge");

endmodule : ahp_monitor

// ### dv/adc_host_port_and_conversion_control_bench.sv
module adc_host_port_and_conversion_control_bench
  import ahp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cfg; // pd fast lp rdc finv inv ext ser
  logic sample_req, result_new_ff, sample_valid_ff, idle_ff;
  logic [DATA_W-1:0] sample_data, sample_ff, result_ff, d2;
  int miscompares = 0;
  int checks = 0;

  always #20 sys_clk = ~sys_clk;

  ahp_if bus_if();
  ahp_if bad_if();

  ahp_dev #(.CONV_CYC(5), .ACQ_CYC(2)) ahp_dev_i (.sys_clk, .rst, .sample_data, .result_ff,
    .result_new_ff, .pins(bus_if.dev));
  ahp_host ahp_host_i (.sys_clk, .rst, .cfg_serial(cfg[0]), .cfg_ext_clk(cfg[1]),
    .cfg_sclk_inv(cfg[2]), .cfg_frame_inv(cfg[3]), .cfg_read_timing(cfg[4]),
    .cfg_low_power(cfg[5]), .cfg_fast(cfg[6]), .cfg_power_down(cfg[7]), .sample_req,
    .sample_ff, .sample_valid_ff, .idle_ff, .pins(bus_if.host));
  ahp_dev #(.CONV_CYC(5), .ACQ_CYC(2)) ahp_dev_i2 (.sys_clk, .rst, .sample_data(d2),
    .result_ff(), .result_new_ff(), .pins(bad_if.dev));
  ahp_monitor ahp_monitor_i (.sys_clk, .rst, .cnv_n(bus_if.cnv_n), .cs_n(bus_if.cs_n),
    .rd_n(bus_if.rd_n), .power_down(bus_if.power_down), .port_select(bus_if.port_select),
    .clock_source_select(bus_if.clock_source_select),
    .frame_marker_polarity(bus_if.frame_marker_polarity), .busy(bus_if.busy),
    .dev_data_o(bus_if.dev_data_o), .dev_data_oe(bus_if.dev_data_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp

  // sel 0: sample done, 1: busy, 2: result latched
  task automatic wait_hi(input int sel, input logic lvl);
    for (int n = 0; n < 900; n++)
    begin
      @(negedge sys_clk);
      if ((sel == 0 ? sample_valid_ff : (sel == 1 ? bus_if.busy : result_new_ff)) === lvl)
        return;
    end
    miscompares++;
    report_and_stop();
  endtask : wait_hi

  task automatic start(input logic [7:0] c, input logic [15:0] d);
    repeat (8) @(negedge sys_clk);
    cfg = c;
    sample_data = d;
    repeat (4) @(negedge sys_clk);
    sample_req = 1'b1;
    @(negedge sys_clk);
    sample_req = 1'b0;
  endtask : start

  // start pulse on the second port; counts late flag (sel 0) or busy highs
  task automatic b_pulse(input int sel, input int rel, output int hi);
    hi = 0;
    bad_if.cnv_n = 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      @(negedge sys_clk);
      if (k == rel)
        bad_if.cnv_n = 1'b1;
      hi += ((sel == 0 ? bad_if.data_pin[PIN_LATE] : bad_if.busy) === 1'b1);
    end
  endtask : b_pulse

  task automatic b_edge();
    bad_if.host_sclk_o = ~bad_if.host_sclk_o;
    repeat (4) @(negedge sys_clk);
  endtask : b_edge

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_modes();
    logic [7:0] m [9] = '{8'h00, 8'h03, 8'h07, 8'h01, 8'h05, 8'h09, 8'h11, 8'h19, 8'h20};
    logic [15:0] d;
    for (int i = 0; i < 9; i++)
    begin
      d = {m[i], 8'h5A} ^ 16'hA3C1;
      start(m[i], d);
      wait_hi(0, 1'b1);
      cmp("word", d, sample_ff);
      cmp("result", d, result_ff);
    end
  endtask : s_modes

  task automatic s_power();
    start(8'h00, 16'h0FF0);
    wait_hi(1, 1'b1);
    cfg = 8'h80;
    wait_hi(2, 1'b1);
    cmp("new result", 16'h0FF0, result_ff);
    wait_hi(0, 1'b1);
    cmp("pd word", 16'h0FF0, sample_ff);
  endtask : s_power

  task automatic s_late();
    logic [15:0] w;
    int hi;
    d2 = 16'hC3A5;
    b_pulse(1, 3, hi);
    repeat (8) b_edge();
    bad_if.cs_n = 1'b0;
    bad_if.rd_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    for (int i = 15; i >= 0; i--)
    begin
      w[i] = bad_if.data_pin[PIN_SOUT];
      b_edge();
      b_edge();
    end
    cmp("ext word", 16'hC3A5, w);
    d2 = 16'h5A3C;
    b_pulse(1, 3, hi);
    repeat (6) b_edge();
    b_pulse(0, 3, hi);
    cmp("late flag", 16'(LATE_PULSE_CYCLES), 16'(hi));
    bad_if.cs_n = 1'b1;
    bad_if.rd_n = 1'b1;
  endtask : s_late

  task automatic s_lowpow();
    int hi;
    bad_if.low_power = 1'b1;
    b_pulse(1, 99, hi);
    cmp("held start", 16'h0001, 16'(hi > 5));
    bad_if.low_power = 1'b0;
    bad_if.cnv_n = 1'b1;
    bad_if.power_down = 1'b1;
    repeat (20) @(negedge sys_clk);
    b_pulse(1, 3, hi);
    cmp("pd start", 16'h0000, 16'(hi));
  endtask : s_lowpow

  task automatic s_reset();
    start(8'h00, 16'h1234);
    wait_hi(1, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp("busy", 16'h0000, {15'h0000, bus_if.busy});
    cmp("oe", 16'h0000, bus_if.dev_data_oe);
    cmp("result", 16'h0000, result_ff);
    rst = 1'b0;
    start(8'h00, 16'hBEEF);
    wait_hi(0, 1'b1);
    cmp("after reset", 16'hBEEF, sample_ff);
    @(negedge sys_clk);
    cmp("idle", 16'h0001, {15'h0000, idle_ff});
  endtask : s_reset

  initial
  begin
    cfg = 8'h00;
    sample_data = 16'h0000;
    sample_req = 1'b0;
    d2 = 16'h0000;
    bad_if.cnv_n = 1'b1;
    bad_if.cs_n = 1'b1;
    bad_if.rd_n = 1'b1;
    bad_if.power_down = 1'b0;
    bad_if.port_select = 1'b1;
    bad_if.clock_source_select = 1'b1;
    bad_if.serial_clock_invert = 1'b0;
    bad_if.frame_marker_polarity = 1'b0;
    bad_if.read_timing_or_chain_in = 1'b0;
    bad_if.low_power = 1'b0;
    bad_if.fast_mode = 1'b0;
    bad_if.host_sclk_o = 1'b0;
    bad_if.host_sclk_oe = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    s_modes();
    s_power();
    s_late();
    s_lowpow();
    s_reset();
    report_and_stop();
  end

endmodule : adc_host_port_and_conversion_control_bench
